// File: hw/rx_overhead_map.svh
`ifndef RX_OVERHEAD_MAP_SVH
`define RX_OVERHEAD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RX_OH_CTRL_ADDR 8'h80
`define RX_OH_SCAN_ADDR 8'h81
`define RX_OH_STAT_ADDR 8'h82
`define RX_OH_MASK_ADDR 8'h83

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RX_OH_CTRL_HDLC_BIT 0
`define RX_OH_SCAN_LOS_BIT 0
`define RX_OH_EV_LOS_ON 0
`define RX_OH_EV_LOS_OFF 1
`define RX_OH_EV_BIT_UNDERRUN 2
`define RX_OH_EV_BYTE_UNDERRUN 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RX_OH_CTRL_RESET 8'h00
`define RX_OH_MASK_RESET 8'h00
`define RX_OH_STAT_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define RX_OH_CLK_HALF_NS 160
`define RX_OH_SYS_PERIOD_NS 40
`define RX_OH_HALF_CYCLES ((`RX_OH_CLK_HALF_NS) / (`RX_OH_SYS_PERIOD_NS))

`endif

// File: hw/rx_overhead_pkg.sv
package rx_overhead_pkg;

  // ----------------------------------------
  // Bus and stream carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic valid;
    logic data;
    logic frame;
  } oh_bit_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pkt_byte_type;

  // ----------------------------------------
  // Block state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] status;
    logic [7:0] rdata;
    logic [2:0] divCount;
    logic ohClk;
    logic ohBit;
    logic ohFrame;
    logic pendValid;
    logic pendBit;
    logic pendFrame;
    logic [7:0] byteOut;
    logic byteValid;
    logic [7:0] byteHold;
    logic losPrev;
  } state_type;

endpackage : rx_overhead_pkg

// File: hw/sync_bit.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module sync_bit (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);

  logic stage1;

  // Only the second stage is read outside
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : sync_bit

`default_nettype wire

// File: hw/rx_overhead_port.sv
// How it works
// - Scan register 0x81 bit 0 shows the current loss-of-signal input level.
// - Loss-of-signal input is active high; low means no signal loss.
// - An asserted loss input makes the receive section declare loss of signal.
// - HDLC mode bit picks overhead clock or packet byte clock role.
// - In normal mode each overhead bit changes on the clock falling edge.
// - The overhead clock toggles continuously, never gated or idle.
// - In HDLC mode the byte output updates on this pin's clock.
`timescale 1ns/1ns
`default_nettype none
`include "rx_overhead_map.svh"

module rx_overhead_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire rx_overhead_pkg::bus_req_type busReq,
  output logic [7:0] busRdata,
  input wire logic external_signal_loss_in,
  input wire logic framerSignalLoss,
  output logic rxSignalLoss,
  input wire rx_overhead_pkg::oh_bit_type ohIn,
  output logic ohReady,
  input wire rx_overhead_pkg::pkt_byte_type byteIn,
  output logic byteReady,
  output logic rx_overhead_clock,
  output logic rx_overhead_bit_out,
  output logic rx_overhead_frame_marker,
  output logic [7:0] rx_packet_byte_out,
  output logic irq
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [2:0] HALF_LAST = 3'(`RX_OH_HALF_CYCLES - 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  rx_overhead_pkg::state_type state;
  rx_overhead_pkg::state_type next_state;

  logic losLevel;
  logic hdlcMode;
  logic fallEdge;
  logic [7:0] events;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // The loss pin comes from another chip, so it is
  // resynchronised before any logic looks at it
  sync_bit losSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(external_signal_loss_in),
    .syncOut(losLevel)
  );

  // ----------------------------------------
  // Mode and handshakes
  // ----------------------------------------
  // Pin role follows the mode bit directly
  assign hdlcMode = state.ctrl[`RX_OH_CTRL_HDLC_BIT];

  // One slot only: ready while the slot is empty
  assign ohReady = !hdlcMode && !state.pendValid;
  assign byteReady = hdlcMode && !state.byteValid;

  // A falling edge is due when the clock is high at the end of a half
  assign fallEdge = state.ohClk && (state.divCount == HALF_LAST);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.rdata = 8'h00;
    events = 8'h00;

    // Free-running divider; it never stops, in either mode
    if (state.divCount == HALF_LAST)
    begin
      next_state.divCount = 3'h0;
      next_state.ohClk = !state.ohClk;
    end
    else
    begin
      next_state.divCount = state.divCount + 3'h1;
    end

    // Overhead bits launch on the falling edge so the far end
    // sees them settled half a period before its rising edge
    if (fallEdge && !hdlcMode)
    begin
      if (state.pendValid)
      begin
        next_state.ohBit = state.pendBit;
        next_state.ohFrame = state.pendFrame;
        next_state.pendValid = 1'b0;
      end
      else
      begin
        next_state.ohFrame = 1'b0;
        events[`RX_OH_EV_BIT_UNDERRUN] = 1'b1;
      end
    end

    // Packet bytes use the same edge in HDLC mode
    if (fallEdge && hdlcMode)
    begin
      if (state.byteValid)
      begin
        next_state.byteOut = state.byteHold;
        next_state.byteValid = 1'b0;
      end
      else
      begin
        events[`RX_OH_EV_BYTE_UNDERRUN] = 1'b1;
      end
    end

    // Fill the slots; ready came from the old state
    if (ohIn.valid && ohReady)
    begin
      next_state.pendValid = 1'b1;
      next_state.pendBit = ohIn.data;
      next_state.pendFrame = ohIn.frame;
    end
    if (byteIn.valid && byteReady)
    begin
      next_state.byteValid = 1'b1;
      next_state.byteHold = byteIn.data;
    end

    // Loss edges; high means the line unit declares loss
    next_state.losPrev = losLevel;
    if (losLevel && !state.losPrev)
    begin
      events[`RX_OH_EV_LOS_ON] = 1'b1;
    end
    if (!losLevel && state.losPrev)
    begin
      events[`RX_OH_EV_LOS_OFF] = 1'b1;
    end

    // Register writes
    if (busReq.wr)
    begin
      case (busReq.addr)
        `RX_OH_CTRL_ADDR:
        begin
          next_state.ctrl = busReq.wdata;
        end
        `RX_OH_MASK_ADDR:
        begin
          next_state.mask = busReq.wdata;
        end
        default:
        begin
          next_state.ctrl = state.ctrl;
        end
      endcase
    end

    // Register reads; status clears on read
    if (busReq.rd)
    begin
      case (busReq.addr)
        `RX_OH_CTRL_ADDR:
        begin
          next_state.rdata = state.ctrl;
        end
        `RX_OH_SCAN_ADDR:
        begin
          next_state.rdata = {7'h00, losLevel};
        end
        `RX_OH_STAT_ADDR:
        begin
          next_state.rdata = state.status;
          next_state.status = 8'h00;
        end
        `RX_OH_MASK_ADDR:
        begin
          next_state.rdata = state.mask;
        end
        default:
        begin
          next_state.rdata = 8'h00;
        end
      endcase
    end

    // New events land after the clear so none is lost
    next_state.status = next_state.status | events;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state.ctrl <= `RX_OH_CTRL_RESET;
      state.mask <= `RX_OH_MASK_RESET;
      state.status <= `RX_OH_STAT_RESET;
      state.rdata <= 8'h00;
      state.divCount <= 3'h0;
      state.ohClk <= 1'b0;
      state.ohBit <= 1'b0;
      state.ohFrame <= 1'b0;
      state.pendValid <= 1'b0;
      state.pendBit <= 1'b0;
      state.pendFrame <= 1'b0;
      state.byteOut <= 8'h00;
      state.byteValid <= 1'b0;
      state.byteHold <= 8'h00;
      state.losPrev <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Loss is declared from the pin or from the framer's own detector
  assign rxSignalLoss = losLevel || framerSignalLoss;

  assign busRdata = state.rdata;
  assign rx_overhead_clock = state.ohClk;
  assign rx_overhead_bit_out = state.ohBit;
  assign rx_overhead_frame_marker = state.ohFrame;
  assign rx_packet_byte_out = state.byteOut;

  // Level interrupt while any unmasked status bit is set
  assign irq = |(state.status & state.mask);

endmodule : rx_overhead_port

`default_nettype wire

// File: test/oh_link_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// Data link end
// ----------------
module oh_link_sink (
  input wire logic ohClk,
  input wire logic ohBit,
  input wire logic ohMark,
  input wire logic [7:0] pktByte,
  output logic [9:0] sampled
);
  // Takes bit, marker and byte on the rising edge, half a period after they moved
  always_ff @(posedge ohClk)
    sampled <= {ohBit, ohMark, pktByte};
endmodule : oh_link_sink
`default_nettype wire

// File: test/rx_overhead_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// Port checks
// ----------------
module rx_overhead_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire rx_overhead_pkg::bus_req_type busReq,
  input wire logic [7:0] busRdata,
  input wire logic external_signal_loss_in,
  input wire logic framerSignalLoss,
  input wire logic rxSignalLoss,
  input wire logic ohReady,
  input wire logic byteReady,
  input wire logic rx_overhead_clock,
  input wire logic rx_overhead_bit_out,
  input wire logic rx_overhead_frame_marker,
  input wire logic [7:0] rx_packet_byte_out
);
  // One domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_clk_high: assert property ($rose(rx_overhead_clock) |-> rx_overhead_clock[*4] ##1 !rx_overhead_clock)
    else $error("clock high");
  a_clk_low: assert property ($fell(rx_overhead_clock) |-> (!rx_overhead_clock)[*4] ##1 rx_overhead_clock)
    else $error("clock low");
  a_bit_hold: assert property (!$fell(rx_overhead_clock) |-> $stable(rx_overhead_bit_out))
    else $error("bit moved");
  a_mark_hold: assert property (!$fell(rx_overhead_clock) |-> $stable(rx_overhead_frame_marker))
    else $error("marker moved");
  a_byte_hold: assert property (!$fell(rx_overhead_clock) |-> $stable(rx_packet_byte_out))
    else $error("byte moved");
  a_one_ready: assert property (!(ohReady && byteReady))
    else $error("two roles");
  a_pin_loss: assert property (external_signal_loss_in[*3] |-> rxSignalLoss)
    else $error("loss missed");
  a_loss_clear: assert property ((!external_signal_loss_in && !framerSignalLoss)[*3] |-> !rxSignalLoss)
    else $error("loss stuck");
  a_rd_idle: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
    else $error("stray data");
  c_bit: cover property ($fell(ohReady));
  c_byte: cover property ($fell(byteReady));
  c_loss: cover property ($rose(rxSignalLoss));
endmodule : rx_overhead_properties
bind rx_overhead_port rx_overhead_properties u_rx_overhead_properties (.sys_clk, .rst, .busReq, .busRdata,
  .external_signal_loss_in, .framerSignalLoss, .rxSignalLoss, .ohReady, .byteReady, .rx_overhead_clock,
  .rx_overhead_bit_out, .rx_overhead_frame_marker, .rx_packet_byte_out);
`default_nettype wire

// File: test/tb_rx_overhead_port.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// Bench
// ----------------
module tb_rx_overhead_port;
  logic sys_clk, rst, lossPin, framerSignalLoss, rxSignalLoss, ohReady, byteReady, ohClk, ohBit, ohMark, irq;
  logic [7:0] busRdata, rd, pktByte;
  logic [9:0] sampled;
  rx_overhead_pkg::bus_req_type busReq;
  rx_overhead_pkg::oh_bit_type ohIn;
  rx_overhead_pkg::pkt_byte_type byteIn;
  int mismatches, check_count, cycles;
  rx_overhead_port u_rx_overhead_port (.sys_clk, .rst, .busReq, .busRdata, .external_signal_loss_in(lossPin),
    .framerSignalLoss, .rxSignalLoss, .ohIn, .ohReady, .byteIn, .byteReady, .rx_overhead_clock(ohClk),
    .rx_overhead_bit_out(ohBit), .rx_overhead_frame_marker(ohMark), .rx_packet_byte_out(pktByte), .irq);
  oh_link_sink u_oh_link_sink (.ohClk, .ohBit, .ohMark, .pktByte, .sampled);
  // Clock, and a hang guard well past the hundred or so cycles needed
  initial
  begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // One register cycle; read data is caught in the cycle after the strobe
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{a, d, w, !w};
    @(posedge sys_clk);
    busReq <= '0;
    #1 rd = busRdata;
  endtask : bus
  // Offer one unit, then judge what the far end took on the next rising edge
  task offer(input logic hd, input logic [7:0] v, input logic f);
    while (!(hd ? byteReady : ohReady))
      @(posedge sys_clk);
    @(posedge sys_clk);
    if (hd)
      byteIn <= '{1'b1, v};
    else
      ohIn <= '{1'b1, v[0], f};
    @(posedge sys_clk);
    ohIn.valid <= 0;
    byteIn.valid <= 0;
    #1;
    @(negedge ohClk);
    @(posedge ohClk);
    #1;
    if (hd)
      chk("byte", {2'b00, v}, sampled);
    else
      chk("bit", {v[0], f}, sampled[9:8]);
  endtask : offer
  task loss_path();
    bus(1, 8'h83, 8'h01);
    bus(0, 8'h81, 0);
    chk("scan", 0, rd[0]);
    bus(0, 8'h82, 0);
    @(posedge sys_clk);
    lossPin <= 1;
    repeat (4) @(posedge sys_clk);
    #1 chk("loss", 1, rxSignalLoss);
    chk("irq", 1, irq);
    bus(0, 8'h81, 0);
    chk("scan", 1, rd[0]);
    bus(0, 8'h82, 0);
    chk("status", 1, rd[0]);
    chk("irq", 0, irq);
    @(posedge sys_clk);
    lossPin <= 0;
    framerSignalLoss <= 1;
    repeat (4) @(posedge sys_clk);
    #1 chk("framer", 1, rxSignalLoss);
    chk("irq", 0, irq);
    @(posedge sys_clk);
    framerSignalLoss <= 0;
    @(posedge sys_clk);
    #1 chk("loss", 0, rxSignalLoss);
  endtask : loss_path
  task modes();
    bus(0, 8'h80, 0);
    chk("mode", 0, rd);
    offer(0, 8'h01, 1);
    offer(0, 8'h00, 0);
    bus(1, 8'h80, 8'h01);
    chk("ready", 1, {ohReady, byteReady});
    offer(1, 8'ha5, 0);
    offer(1, 8'h3c, 0);
    bus(1, 8'h80, 0);
    chk("ready", 2, {ohReady, byteReady});
  endtask : modes
  initial
  begin
    rst = 1;
    busReq = '0;
    ohIn = '0;
    byteIn = '0;
    lossPin = 0;
    framerSignalLoss = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    loss_path();
    modes();
    print_verdict();
  end
endmodule : tb_rx_overhead_port
`default_nettype wire
